// [legacy_regs.vh]
// Register offsets, fields, reset values and timing for legacy mode select
// Summary of operation
// - Short decode: match lines 0-9, ignore six upper
// - No short jumper: match lines 0-10 only
// - Short decode chosen by address-width jumper
// - Short decode: burst registers also indexed
// - Mode jumpers pick basic, burst or 12-bit mode
// - Burst mode: per-sample or per-burst interrupt
// - Superset jumper in burst mode enables FIFO extras, status
// - Burst mode always selects the big FIFO
// - Prefetch enable inserts 2048-sample prefetch FIFO
// - DAC width jumper: 16-bit else 12-bit
// - Filter jumper averages every channel, any mode
// - Result is sum of up to sixteen samples over sixteen
// - Channel write clears filter history
// - Channel register resets to zero, channel 0
// - Low above high: no wrap, low only
// - Conversion output on busy or channel write
// - Counter outputs low while unprogrammed
// - Bus reset clears counter block
// - No DMA transfers in this configuration
// - Byte and word accesses both supported
// - Aggregate conversion rate at most 200K/s
`ifndef LEGACY_REGS_VH
`define LEGACY_REGS_VH

// Printed register indexes; byte address is four times the index
`define IDX_ADC_DATA      4'h0
`define IDX_CHAN          4'h2
`define IDX_DAC_A         4'h4
`define IDX_DAC_B         4'h6
`define ADDR_ADC_DATA     8'h00
`define ADDR_CHAN         8'h08
`define ADDR_DAC_A        8'h10
`define ADDR_DAC_B        8'h18
`define ADDR_CONFIG       8'h40
`define ADDR_STATUS       8'h44
`define ADDR_TIMER        8'h48

`define CHAN_RESET        8'h00
`define CHAN_LO_LSB       0
`define CHAN_HI_LSB       4
`define CONFIG_PREFETCH   0
`define DAC_RESET         16'h0000
`define DAC_LEGACY_MASK   16'h0fff
`define TIMER_RESET       16'h0000

// Status field positions
`define ST_BASIC16        0
`define ST_BURST          1
`define ST_TWELVE         2
`define ST_SUPERSET       3
`define ST_FIFO_VIS       4
`define ST_IRQ_BURST      5
`define ST_BIG_FIFO       6
`define ST_PREFETCH       7
`define ST_DAC16          8
`define ST_FILTER         9
`define ST_SHORT          10
`define ST_INDEXED        11
`define ST_READY          12

`define CLK_PERIOD_NS     50
`define SAMPLE_PERIOD_NS  5000
`define PREFETCH_DEPTH    2048
`define FILTER_TAPS       16
`define JUMPER_SETTLE     3

`endif

// [legacy_mode_select.v]
// Jumper mode select, register slave, channel sequencer and average filter
//
// Our own choices: register access over APB and the register offsets.
`default_nettype none
`include "legacy_regs.vh"

module legacy_mode_select #(
  parameter CHANNELS = 16,
  parameter DATA_W   = 16
) (
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Jumpers, high when installed
  input  wire        burst_mode_jumper,
  input  wire        fifo_superset_jumper,
  input  wire        dac_width_jumper,
  input  wire        average_filter_jumper,
  input  wire        short_decode_jumper,
  input  wire        twelve_bit_legacy_jumper,
  input  wire [5:0]  base_jumpers,
  // Host address decode
  input  wire [15:0] host_addr,
  output reg         host_io_hit,
  output reg         indexed_burst_regs,
  // Mode view
  output reg         mode_basic16,
  output reg         mode_burst,
  output reg         mode_twelve_bit,
  output reg         superset_enable,
  output reg         fifo_status_visible,
  output reg         big_fifo_select,
  output reg         prefetch_fifo_enable,
  output reg         dma_request,
  // Converter
  input  wire        adc_busy,
  input  wire        adc_done,
  input  wire [15:0] adc_sample,
  input  wire        burst_done,
  output reg         adc_start,
  output reg  [3:0]  adc_channel,
  output reg         conversion_active_out,
  output reg         acq_irq,
  // DAC and counter
  output reg  [15:0] dac_a,
  output reg  [15:0] dac_b,
  output reg         counter_out
);

  localparam integer SAMPLE_CYC =
    (`SAMPLE_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam integer HIST_W = 4;
  localparam integer SUM_W  = DATA_W + HIST_W;

  // Jumper synchronisers
  reg [5:0] jmp_meta;
  reg [5:0] jmp_sync;
  reg [5:0] jmp;
  reg [1:0] settle;
  reg       cfg_ready;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jmp_meta  <= 6'h00;
      jmp_sync  <= 6'h00;
      jmp       <= 6'h00;
      settle    <= 2'd0;
      cfg_ready <= 1'b0;
    end else begin
      jmp_meta <= {twelve_bit_legacy_jumper, short_decode_jumper,
                   average_filter_jumper, dac_width_jumper,
                   fifo_superset_jumper, burst_mode_jumper};
      jmp_sync <= jmp_meta;
      // Captured once after release; later jumper moves are ignored
      if (!cfg_ready) begin
        if ({30'd0, settle} == `JUMPER_SETTLE) begin
          jmp       <= jmp_sync;
          cfg_ready <= 1'b1;
        end else begin
          settle <= settle + 2'd1;
        end
      end
    end
  end

  wire j_burst  = jmp[0];
  wire j_super  = jmp[1];
  wire j_dac16  = jmp[2];
  wire j_filter = jmp[3];
  wire j_short  = jmp[4];
  wire j_twelve = jmp[5];

  // Mode decode
  wire m_basic  = !j_twelve && !j_super && !j_burst;
  wire m_burst  = !j_twelve && j_burst;
  wire m_twelve = j_twelve && !j_super && !j_burst;
  wire m_super  = !j_twelve && j_super;

  // APB decode
  wire        acc    = psel && penable && !pready;
  wire        wr     = acc && pwrite;
  wire        rd     = acc && !pwrite;
  wire        hit_ad = paddr == `ADDR_ADC_DATA;
  wire        hit_ch = paddr == `ADDR_CHAN;
  wire        hit_da = paddr == `ADDR_DAC_A;
  wire        hit_db = paddr == `ADDR_DAC_B;
  wire        hit_cf = paddr == `ADDR_CONFIG;
  wire        hit_st = paddr == `ADDR_STATUS;
  wire        hit_tm = paddr == `ADDR_TIMER;
  wire        mapped = hit_ad | hit_ch | hit_da | hit_db |
                       hit_cf | hit_st | hit_tm;
  wire        chan_wr = wr && hit_ch && pstrb[0];

  reg  [7:0]  chan;
  reg  [15:0] timer_reload;
  reg  [15:0] adc_result;
  wire [3:0]  lo = chan[`CHAN_LO_LSB +: 4];
  wire [3:0]  hi = chan[`CHAN_HI_LSB +: 4];

  // Byte lanes let the host use byte or word cycles
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] wd;
    input [3:0]  st;
    begin
      merge16 = {st[1] ? wd[15:8] : old[15:8],
                 st[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  wire [15:0] dac_mask = j_dac16 ? 16'hffff : `DAC_LEGACY_MASK;
  wire [15:0] next_dac_a = merge16(dac_a, pwdata, pstrb) & dac_mask;
  wire [15:0] next_dac_b = merge16(dac_b, pwdata, pstrb) & dac_mask;

  wire [15:0] status_word = {3'b000, cfg_ready, indexed_burst_regs,
    j_short, j_filter, j_dac16, prefetch_fifo_enable, big_fifo_select,
    m_burst && j_super, fifo_status_visible, superset_enable,
    m_twelve, m_burst, m_basic};

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (1'b1)
      hit_ad: rd_mux = {16'h0000, adc_result};
      hit_ch: rd_mux = {24'h00_0000, chan};
      hit_cf: rd_mux = {31'h0000_0000, prefetch_fifo_enable};
      hit_st: rd_mux = {16'h0000, status_word};
      hit_tm: rd_mux = {16'h0000, timer_reload};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // One wait state: pready rises on the second access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready               <= 1'b0;
      pslverr              <= 1'b0;
      prdata               <= 32'h0000_0000;
      chan                 <= `CHAN_RESET;
      dac_a                <= `DAC_RESET;
      dac_b                <= `DAC_RESET;
      prefetch_fifo_enable <= 1'b0;
      timer_reload         <= `TIMER_RESET;
    end else begin
      pready  <= acc;
      pslverr <= acc && !mapped;
      prdata  <= rd ? rd_mux : 32'h0000_0000;
      if (chan_wr)
        chan <= pwdata[7:0];
      if (wr && hit_da)
        dac_a <= next_dac_a;
      if (wr && hit_db)
        dac_b <= next_dac_b;
      if (wr && hit_cf && pstrb[0])
        prefetch_fifo_enable <= pwdata[`CONFIG_PREFETCH];
      if (wr && hit_tm)
        timer_reload <= merge16(timer_reload, pwdata, pstrb);
    end
  end

  // Host address decode and mode outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_io_hit         <= 1'b0;
      indexed_burst_regs  <= 1'b0;
      mode_basic16        <= 1'b0;
      mode_burst          <= 1'b0;
      mode_twelve_bit     <= 1'b0;
      superset_enable     <= 1'b0;
      fifo_status_visible <= 1'b0;
      big_fifo_select     <= 1'b0;
      dma_request         <= 1'b0;
    end else begin
      if (j_short)
        host_io_hit <= host_addr[9:4] == base_jumpers;
      else
        host_io_hit <= host_addr[10:4] == {1'b0, base_jumpers};
      indexed_burst_regs  <= j_short;
      mode_basic16        <= cfg_ready && m_basic;
      mode_burst          <= cfg_ready && m_burst;
      mode_twelve_bit     <= cfg_ready && m_twelve;
      superset_enable     <= cfg_ready && m_super;
      fifo_status_visible <= cfg_ready && m_burst && j_super;
      big_fifo_select     <= cfg_ready && m_burst;
      dma_request         <= 1'b0;
    end
  end

  // Channel sequencer with rate limit
  reg [6:0] rate_cnt;
  reg [3:0] cur;
  wire      rate_ok = rate_cnt == 7'd0;
  wire      start   = rate_ok && !adc_busy && !adc_start &&
                      cfg_ready && !chan_wr;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_cnt              <= 7'd0;
      cur                   <= 4'h0;
      adc_start             <= 1'b0;
      adc_channel           <= 4'h0;
      conversion_active_out <= 1'b0;
    end else begin
      adc_start             <= start;
      conversion_active_out <= adc_busy || chan_wr;
      if (start)
        rate_cnt <= SAMPLE_CYC[6:0] - 7'd1;
      else if (!rate_ok)
        rate_cnt <= rate_cnt - 7'd1;
      if (chan_wr) begin
        cur <= pwdata[3:0];
      end else if (start) begin
        adc_channel <= cur;
        if (cur >= hi || lo > hi)
          cur <= lo;
        else
          cur <= cur + 4'h1;
      end
    end
  end

  // Moving average memory; per-channel ring, sum and fill count
  reg [DATA_W-1:0] hist [0:CHANNELS*`FILTER_TAPS-1];
  reg [SUM_W-1:0]  sum  [0:CHANNELS-1];
  reg [HIST_W-1:0] wptr [0:CHANNELS-1];
  reg [HIST_W:0]   fill [0:CHANNELS-1];
  integer i;

  wire [3:0]        dch     = adc_channel;
  wire [7:0]        haddr   = {dch, wptr[dch]};
  wire [DATA_W-1:0] oldest  = fill[dch][HIST_W] ? hist[haddr] :
                              {DATA_W{1'b0}};
  wire [SUM_W-1:0]  next_sum = sum[dch] + {4'h0, adc_sample} -
                               {4'h0, oldest};

  always @(posedge pclk) begin
    if (adc_done)
      hist[haddr] <= adc_sample;
  end

  // Channel write empties every history; old ring words are masked by fill
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        sum[i]  <= {SUM_W{1'b0}};
        wptr[i] <= {HIST_W{1'b0}};
        fill[i] <= {(HIST_W+1){1'b0}};
      end
    end else if (chan_wr) begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        sum[i]  <= {SUM_W{1'b0}};
        wptr[i] <= {HIST_W{1'b0}};
        fill[i] <= {(HIST_W+1){1'b0}};
      end
    end else if (adc_done) begin
      sum[dch]  <= next_sum;
      wptr[dch] <= wptr[dch] + {{(HIST_W-1){1'b0}}, 1'b1};
      if (!fill[dch][HIST_W])
        fill[dch] <= fill[dch] + {{HIST_W{1'b0}}, 1'b1};
    end
  end

  // Result and interrupt events
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_result <= 16'h0000;
      acq_irq    <= 1'b0;
    end else begin
      if (adc_done) begin
        if (j_filter)
          adc_result <= next_sum[SUM_W-1:HIST_W];
        else
          adc_result <= adc_sample;
      end
      if (m_burst && j_super)
        acq_irq <= burst_done;
      else
        acq_irq <= adc_done;
    end
  end

  // Counter block; idles low until a reload value is written
  reg [15:0] tcount;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcount      <= 16'h0000;
      counter_out <= 1'b0;
    end else if (timer_reload == `TIMER_RESET) begin
      tcount      <= 16'h0000;
      counter_out <= 1'b0;
    end else if (tcount == 16'h0000) begin
      tcount      <= timer_reload - 16'h0001;
      counter_out <= !counter_out;
    end else begin
      tcount <= tcount - 16'h0001;
    end
  end

endmodule
`default_nettype wire

// [adc_model.sv]
// Converter model answering each start pulse after a fixed latency
`default_nettype none
module adc_model #(
  parameter int LAT = 20
) (
  // Clock, reset and request
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        adc_start,
  // Answer
  output logic             adc_busy,
  output logic             adc_done,
  output logic [15:0]      adc_sample
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      adc_busy <= 1'b0;
      adc_done <= 1'b0;
      adc_sample <= 16'h0000;
    end else begin
      adc_done <= (cnt == 1);
      // Data only valid with done; toggles otherwise so no stale match
      adc_sample <= (cnt == 1) ? 16'h0160 : ~adc_sample;
      if (adc_start) begin
        cnt <= LAT;
        adc_busy <= 1'b1;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
        adc_busy <= (cnt > 1);
      end
    end
  end
endmodule
`default_nettype wire

// [legacy_mode_select_props.sv]
// Port-level assertions for the jumper mode select block
`default_nettype none
module legacy_mode_select_chk (
  // Bus
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic [3:0] pstrb,
  input wire logic       pready,
  input wire logic       pslverr,
  // Converter
  input wire logic       adc_busy,
  input wire logic       adc_done,
  input wire logic       burst_done,
  input wire logic       adc_start,
  input wire logic       acq_irq,
  input wire logic       conversion_active_out,
  // Mode view
  input wire logic       dma_request,
  input wire logic       mode_basic16,
  input wire logic       mode_burst,
  input wire logic       mode_twelve_bit,
  input wire logic       superset_enable,
  input wire logic       big_fifo_select,
  input wire logic       fifo_status_visible,
  input wire logic       short_decode_jumper,
  input wire logic       indexed_burst_regs
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic cfg = mode_basic16 | mode_burst | mode_twelve_bit;
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_chan_wr;
    psel && penable && !pready && pwrite && paddr == 8'h08 && pstrb[0];
  endsequence
  a_ready_one_wait: assert property (s_access |=> pready ##1 !pready)
    else $error("pready not one cycle after access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_conv_on_write: assert property (
    s_chan_wr |=> conversion_active_out)
    else $error("no conversion flag after channel write");
  a_conv_on_busy: assert property (adc_busy |=> conversion_active_out)
    else $error("no conversion flag while busy");
  a_no_dma: assert property (!dma_request)
    else $error("dma request raised");
  a_start_spacing: assert property (adc_start |=> !adc_start [*8])
    else $error("conversion starts too close");
  a_irq_burst: assert property (cfg && mode_burst && superset_enable
    && burst_done |=> acq_irq) else $error("no irq after burst end");
  a_irq_sample: assert property (
    cfg && !(mode_burst && superset_enable)
    && adc_done |=> acq_irq) else $error("no irq after sample");
  a_burst_fifo: assert property (mode_burst |-> big_fifo_select
    && fifo_status_visible == superset_enable) else $error("burst fifo view");
  a_index_short: assert property (cfg |-> indexed_burst_regs
    == short_decode_jumper) else $error("indexed view wrong");
  a_twelve_only: assert property (mode_twelve_bit |-> !mode_burst
    && !superset_enable && !mode_basic16) else $error("twelve mode mixed");
endmodule
bind legacy_mode_select legacy_mode_select_chk u_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pstrb, .pready, .pslverr, .adc_busy,
  .adc_done,
  .burst_done, .adc_start, .acq_irq, .conversion_active_out, .dma_request,
  .mode_basic16, .mode_burst, .mode_twelve_bit, .superset_enable,
  .big_fifo_select, .fifo_status_visible, .short_decode_jumper,
  .indexed_burst_regs);
`default_nettype wire

// [test_legacy_mode_select_and_adc_average.sv]
// Bench for the jumper mode select block with a converter model
`default_nettype none
module test_legacy_mode_select_and_adc_average;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [5:0] j; logic [31:0] st;} row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic burst_done = 0, chk_ch = 0, e, pready, pslverr, host_io_hit;
  logic adc_busy, adc_done, adc_start, counter_out;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, r, prdata;
  logic [3:0] pstrb = 4'h0, adc_channel;
  logic [5:0] jmp = 6'h00;
  logic [15:0] adc_sample, dac_a, dac_b, haddr = 16'hff00;
  int error_cnt = 0, comparisons = 0, dn = 0, d0, n;
  // Jumper order: twelve, short, filter, dac, superset, burst
  row_t rows [5] = '{'{6'b000000, 32'h0000_1001},
    '{6'b000001, 32'h0000_1042}, '{6'b000011, 32'h0000_107a},
    '{6'b100000, 32'h0000_1004}, '{6'b011100, 32'h0000_1f01}};
  always #25 pclk = ~pclk;
  legacy_mode_select dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .burst_mode_jumper(jmp[0]), .fifo_superset_jumper(jmp[1]),
    .dac_width_jumper(jmp[2]), .average_filter_jumper(jmp[3]),
    .short_decode_jumper(jmp[4]), .twelve_bit_legacy_jumper(jmp[5]),
    .base_jumpers(6'h30), .host_addr(haddr), .host_io_hit,
    .indexed_burst_regs(), .mode_basic16(), .mode_burst(),
    .mode_twelve_bit(), .superset_enable(), .fifo_status_visible(),
    .big_fifo_select(), .prefetch_fifo_enable(), .dma_request(), .adc_busy,
    .adc_done, .adc_sample, .burst_done, .adc_start, .adc_channel,
    .conversion_active_out(), .acq_irq(), .dac_a, .dac_b, .counter_out);
  adc_model #(.LAT(20)) u_adc (.pclk, .presetn, .adc_start, .adc_busy,
    .adc_done, .adc_sample);
  always @(posedge pclk) if (adc_done === 1'b1) dn <= dn + 1;
  always @(posedge pclk) begin
    if (chk_ch && adc_start === 1'b1) begin
      cmp("channel", 32'h3, {28'h0, adc_channel});
    end
  end
  task automatic cmp(input string s, input logic [31:0] x,
                     input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) error_cnt++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rst();
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
  task automatic wait_done(input int target);
    n = 0;
    while (dn < target && n < 2500) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2500) error_cnt++;
  endtask
  task automatic summarize();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    summarize();
  end
  initial begin
    for (int i = 0; i < 5; i++) begin
      jmp <= rows[i].j;
      haddr <= 16'hff00;
      rst();
      apb(1'b0, 8'h44, 32'h0, 4'hf);
      cmp("status", rows[i].st, r);
      apb(1'b0, 8'h08, 32'h0, 4'hf);
      cmp("chan", 32'h0, r);
      apb(1'b1, 8'h10, 32'h0000_ffff, 4'hf);
      cmp("dac_a", rows[i].j[2] ? 32'hffff : 32'h0fff, 32'(dac_a));
      apb(1'b1, 8'h18, 32'h0000_a5a5, 4'hf);
      cmp("dac_b", rows[i].j[2] ? 32'ha5a5 : 32'h05a5, 32'(dac_b));
      cmp("hit", {31'h0, rows[i].j[4]}, {31'h0, host_io_hit});
      // A10 low: both decode widths must match this base
      haddr <= 16'h0300;
      repeat (2) @(posedge pclk);
      cmp("hit low", 32'h1, {31'h0, host_io_hit});
      cmp("counter", 32'h0, {31'h0, counter_out});
      @(posedge pclk) burst_done <= 1'b1;
      @(posedge pclk) burst_done <= 1'b0;
    end
    // Awkward cases on the filter configuration
    apb(1'b0, 8'h4c, 32'h0, 4'hf);
    cmp("unmapped", 32'h1, {31'h0, e});
    apb(1'b1, 8'h44, 32'h0, 4'hf);
    apb(1'b1, 8'h40, 32'h1, 4'hf);
    apb(1'b0, 8'h44, 32'h0, 4'hf);
    cmp("prefetch", 32'h0000_1f81, r);
    apb(1'b1, 8'h10, 32'h1234_5678, 4'h1);
    cmp("byte lane", 32'hff78, {16'h0, dac_a});
    apb(1'b1, 8'h48, 32'h4, 4'hf);
    n = 0;
    while (counter_out !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    cmp("counter run", 32'h1, {31'h0, counter_out});
    // High phase lasts one reload period
    n = 0;
    while (counter_out === 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    cmp("counter period", 32'h4, n);
    rst();
    cmp("counter reset", 32'h0, {31'h0, counter_out});
    apb(1'b0, 8'h48, 32'h0, 4'hf);
    cmp("timer reset", 32'h0, r);
    // Clear history right after a sample so none is in flight
    wait_done(dn + 1);
    apb(1'b1, 8'h08, 32'h3, 4'hf);
    chk_ch = 1'b1;
    d0 = dn;
    wait_done(d0 + 1);
    apb(1'b0, 8'h00, 32'h0, 4'hf);
    cmp("avg first", 32'h0016, r);
    wait_done(d0 + 16);
    apb(1'b0, 8'h00, 32'h0, 4'hf);
    cmp("avg full", 32'h0160, r);
    // Seventeenth sample must drop the oldest one from the sum
    wait_done(d0 + 17);
    apb(1'b0, 8'h00, 32'h0, 4'hf);
    cmp("avg slide", 32'h0160, r);
    summarize();
  end
endmodule
`default_nettype wire
